/* rtl/ltc_top.sv */
// Summary of operation
// - Single, demand and verify transfers are served and the address only counts up.
// - Block mode, address decrement and cascade on ordinary channels are absent.
// - No memory-to-memory path and no external termination input exist.
// - Channels 0-3 on the first controller move one byte per transfer.
// - Channels 5-7 on the second controller move a 16-bit word per transfer.
// - No transfer wider than 16 bits is ever issued on any channel.
// - Channel 4 carries only bus-master ownership requests.
// - Each channel keeps 16-bit reload and working address and count values.
// - Working address and count are 16 bits, eight of each, and readable.
// - Channel 4 address and count registers are accessible but unused.
// - Only command bit 2 acts, enabling its controller; other bits are dropped.
// - Arbitration is always fixed priority, lowest channel first.
// - Mode bits 7:6 give demand for 00 and single for 01; 10 and 11 do nothing.
// - Mode bit 4 reloads working address and count when the count expires.
// - Channel 4 is fixed in cascade use; no other channel can cascade.
`timescale 1ns/1ps
module ltc_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [ltc_pkg::REG_AW-1:0] reg_addr,
  input wire logic [ltc_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ltc_pkg::REG_DW-1:0] reg_rdata,
  // Peripheral requests, one per channel
  input wire logic [7:0] dreq,
  // Bus-master ownership
  output logic bm_grant,
  // Transfer stream towards the link
  output logic xfer_valid,
  input wire logic xfer_ready,
  output logic [16:0] xfer_addr,
  output logic [2:0] xfer_chan,
  output logic [1:0] xfer_kind,
  output logic xfer_wide,
  output logic xfer_last
);

  // Counters are held as 16-bit registers throughout
  if (CNT_W != 16) begin : g_chk
    $error("ltc_top: CNT_W must be 16");
  end

  typedef struct packed {
    logic [7:0][15:0] base_addr;
    logic [7:0][15:0] base_cnt;
    logic [7:0][15:0] cur_addr;
    logic [7:0][15:0] cur_cnt;
    logic [7:0][4:0] mode;
    logic [1:0] ctl_en;
    logic [1:0][3:0] mask;
    logic [1:0][3:0] tc;
    ltc_pkg::ltc_state_t state;
    logic [2:0] chan;
    logic [ltc_pkg::BUF_ENTRIES-1:0] full;
    ltc_pkg::ltc_desc_t [ltc_pkg::BUF_ENTRIES-1:0] slot;
    logic bm_grant;
    logic [15:0] rdata;
  } ltc_regs_t;

  ltc_regs_t st_r;
  ltc_regs_t st_nxt;

  // Controller that owns a channel number
  function automatic logic ctl_of(input logic [2:0] ch);
    ctl_of = ch[2];
  endfunction : ctl_of

  // Mode byte as software sees it, channel select in bits 1:0
  function automatic logic [7:0] mode_byte(input logic [4:0] m,
                                           input logic [2:0] ch);
    mode_byte = {m[4:3], 1'b0, m[2], m[1:0], ch[1:0]};
  endfunction : mode_byte

  logic [7:0] elig;
  logic [7:0] cand;
  logic any_cand;
  logic [2:0] pick;
  logic room;
  logic pop;
  logic do_issue;
  logic [2:0] ic;
  ltc_pkg::ltc_desc_t d;
  logic [2:0] wch;
  logic wc;
  logic [1:0] wfld;

  // Channel eligibility; cascade and illegal codes never transfer
  always_comb begin
    elig = '0;
    for (int c = 0; c < 8; c++) begin
      elig[c] = dreq[c] && st_r.ctl_en[ctl_of(3'(c))]
        && !st_r.mask[ctl_of(3'(c))][c % 4]
        && (st_r.mode[c][4:3] == ltc_pkg::OP_DEMAND
            || st_r.mode[c][4:3] == ltc_pkg::OP_SINGLE)
        && st_r.mode[c][1:0] != ltc_pkg::XF_ILLEGAL
        && 3'(c) != ltc_pkg::BM_CHAN;
    end
    cand = elig;
    cand[ltc_pkg::BM_CHAN] = dreq[ltc_pkg::BM_CHAN]
      && st_r.ctl_en[1] && !st_r.mask[1][0];
    any_cand = |cand;
  end

  // Fixed priority, lowest channel wins; no rotation exists
  always_comb begin
    pick = 3'h0;
    for (int c = 7; c >= 0; c--) begin
      if (cand[c]) begin
        pick = 3'(c);
      end
    end
  end

  // Register write decode
  assign wch = reg_addr[4:2];
  assign wfld = reg_addr[1:0];
  assign wc = reg_addr[0];

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 16'h0000;
    room = !st_r.full[1];
    pop = st_r.full[0] && xfer_ready;
    do_issue = 1'b0;
    ic = st_r.chan;
    d = '0;

    // Register reads; status read clears its expiry flags
    if (reg_rd) begin
      if (reg_addr <= ltc_pkg::CH_REG_LAST) begin
        case (wfld)
          ltc_pkg::FLD_BASE_ADDR: st_nxt.rdata = st_r.base_addr[wch];
          ltc_pkg::FLD_BASE_CNT: st_nxt.rdata = st_r.base_cnt[wch];
          ltc_pkg::FLD_CUR_ADDR: st_nxt.rdata = st_r.cur_addr[wch];
          default: st_nxt.rdata = st_r.cur_cnt[wch];
        endcase
      end else if (reg_addr[7:3] == ltc_pkg::MODE_RD_BASE[7:3]) begin
        if (reg_addr[2:0] == ltc_pkg::BM_CHAN) begin
          st_nxt.rdata = {8'h00, ltc_pkg::OP_CASCADE,
                          6'(ltc_pkg::BM_CHAN[1:0])};
        end else begin
          st_nxt.rdata = {8'h00, mode_byte(st_r.mode[reg_addr[2:0]],
                                           reg_addr[2:0])};
        end
      end else begin
        case (reg_addr)
          ltc_pkg::CMD0, ltc_pkg::CMD1:
            st_nxt.rdata = 16'(st_r.ctl_en[wc]) << ltc_pkg::CMD_EN_BIT;
          ltc_pkg::STAT0, ltc_pkg::STAT1: begin
            st_nxt.rdata = {8'h00, (wc ? dreq[7:4] : dreq[3:0]),
                            st_r.tc[wc]};
            st_nxt.tc[wc] = 4'h0;
          end
          ltc_pkg::MASK0, ltc_pkg::MASK1:
            st_nxt.rdata = {12'h000, st_r.mask[wc]};
          default: st_nxt.rdata = 16'h0000;
        endcase
      end
    end

    // Register writes
    if (reg_wr) begin
      if (reg_addr <= ltc_pkg::CH_REG_LAST) begin
        case (wfld)
          // Loading the reload value primes the working copy too
          ltc_pkg::FLD_BASE_ADDR: begin
            st_nxt.base_addr[wch] = reg_wdata;
            st_nxt.cur_addr[wch] = reg_wdata;
          end
          ltc_pkg::FLD_BASE_CNT: begin
            st_nxt.base_cnt[wch] = reg_wdata;
            st_nxt.cur_cnt[wch] = reg_wdata;
          end
          ltc_pkg::FLD_CUR_ADDR: st_nxt.cur_addr[wch] = reg_wdata;
          default: st_nxt.cur_cnt[wch] = reg_wdata;
        endcase
      end else begin
        case (reg_addr)
          ltc_pkg::MODE_WR0, ltc_pkg::MODE_WR1: begin
            // Bits 1:0 steer the byte; bit 5 has no effect
            if ({wc, reg_wdata[1:0]} != ltc_pkg::BM_CHAN) begin
              st_nxt.mode[{wc, reg_wdata[1:0]}] =
                {reg_wdata[7:6], reg_wdata[4], reg_wdata[3:2]};
            end
          end
          ltc_pkg::CMD0, ltc_pkg::CMD1:
            st_nxt.ctl_en[wc] = reg_wdata[ltc_pkg::CMD_EN_BIT];
          ltc_pkg::MASK0, ltc_pkg::MASK1:
            st_nxt.mask[wc] = reg_wdata[3:0];
          default: ;
        endcase
      end
    end

    // Arbitration and sequencing
    case (st_r.state)
      ltc_pkg::ST_IDLE: begin
        if (any_cand && pick == ltc_pkg::BM_CHAN) begin
          st_nxt.state = ltc_pkg::ST_MASTER;
          st_nxt.bm_grant = 1'b1;
        end else if (any_cand && room) begin
          do_issue = 1'b1;
          ic = pick;
          st_nxt.chan = pick;
          // Demand holds the channel; single re-arbitrates each time
          if (st_r.mode[pick][4:3] == ltc_pkg::OP_DEMAND) begin
            st_nxt.state = ltc_pkg::ST_RUN;
          end
        end
      end
      ltc_pkg::ST_RUN: begin
        if (!elig[st_r.chan]) begin
          st_nxt.state = ltc_pkg::ST_IDLE;
        end else if (room) begin
          do_issue = 1'b1;
        end
      end
      ltc_pkg::ST_MASTER: begin
        if (!cand[ltc_pkg::BM_CHAN]) begin
          st_nxt.state = ltc_pkg::ST_IDLE;
          st_nxt.bm_grant = 1'b0;
        end
      end
      default: begin
        st_nxt.state = ltc_pkg::ST_IDLE;
        st_nxt.bm_grant = 1'b0;
      end
    endcase

    // One transfer: build it, step address up, count down
    if (do_issue) begin
      d.wide = ic[2];
      // Word channels address words, so the byte address doubles
      d.addr = d.wide ? {st_r.cur_addr[ic], 1'b0}
                      : {1'b0, st_r.cur_addr[ic]};
      d.chan = ic;
      d.kind = st_r.mode[ic][1:0];
      d.last = (st_r.cur_cnt[ic] == 16'h0000);
      st_nxt.cur_addr[ic] = st_r.cur_addr[ic] + 16'h0001;
      st_nxt.cur_cnt[ic] = st_r.cur_cnt[ic] - 16'h0001;
      // Count expiry ends a run, as does loss of eligibility (request, mask, enable) in ST_RUN; there is no termination input
      if (d.last) begin
        st_nxt.tc[ic[2]][ic[1:0]] = 1'b1;
        st_nxt.state = ltc_pkg::ST_IDLE;
        if (st_r.mode[ic][2]) begin
          st_nxt.cur_addr[ic] = st_r.base_addr[ic];
          st_nxt.cur_cnt[ic] = st_r.base_cnt[ic];
        end else begin
          st_nxt.mask[ic[2]][ic[1:0]] = 1'b1;
        end
      end
    end

    // Two-entry buffer; slot 0 is always the head so outputs stay on flops
    if (pop) begin
      st_nxt.slot[0] = st_r.slot[1];
      st_nxt.full = {1'b0, st_r.full[1]};
    end
    if (do_issue) begin
      if (st_nxt.full[0]) begin
        st_nxt.slot[1] = d;
        st_nxt.full[1] = 1'b1;
      end else begin
        st_nxt.slot[0] = d;
        st_nxt.full[0] = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
      st_r.state <= ltc_pkg::ST_IDLE;
      st_r.mask <= {ltc_pkg::MASK_RST, ltc_pkg::MASK_RST};
      st_r.ctl_en <= {ltc_pkg::CMD_EN_RST, ltc_pkg::CMD_EN_RST};
      st_r.mode <= {8{ltc_pkg::MODE_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_r.rdata;
  assign bm_grant = st_r.bm_grant;
  assign xfer_valid = st_r.full[0];
  assign xfer_addr = st_r.slot[0].addr;
  assign xfer_chan = st_r.slot[0].chan;
  assign xfer_kind = st_r.slot[0].kind;
  assign xfer_wide = st_r.slot[0].wide;
  assign xfer_last = st_r.slot[0].last;

endmodule : ltc_top

/* common/ltc_pkg.sv */
package ltc_pkg;
  // Register port widths
  localparam int REG_AW = 8;
  localparam int REG_DW = 16;

  // Channel registers: address is {channel, field}
  localparam logic [7:0] CH_REG_BASE = 8'h00;
  localparam logic [7:0] CH_REG_LAST = 8'h1F;
  localparam logic [1:0] FLD_BASE_ADDR = 2'h0;
  localparam logic [1:0] FLD_BASE_CNT = 2'h1;
  localparam logic [1:0] FLD_CUR_ADDR = 2'h2;
  localparam logic [1:0] FLD_CUR_CNT = 2'h3;

  // Per-controller registers, controller index in bit 0; mode readback from MODE_RD_BASE is per channel, index in bits 2:0
  localparam logic [7:0] MODE_WR0 = 8'h20;
  localparam logic [7:0] MODE_WR1 = 8'h21;
  localparam logic [7:0] MODE_RD_BASE = 8'h28;
  localparam logic [7:0] CMD0 = 8'h30;
  localparam logic [7:0] CMD1 = 8'h31;
  localparam logic [7:0] STAT0 = 8'h32;
  localparam logic [7:0] STAT1 = 8'h33;
  localparam logic [7:0] MASK0 = 8'h34;
  localparam logic [7:0] MASK1 = 8'h35;

  // Field positions
  localparam int CMD_EN_BIT = 2;
  localparam int MODE_OP_LSB = 6;
  localparam int MODE_AUTO_BIT = 4;
  localparam int MODE_XFER_LSB = 2;

  // Operating codes in mode bits 7:6 and 3:2
  localparam logic [1:0] OP_DEMAND = 2'h0;
  localparam logic [1:0] OP_SINGLE = 2'h1;
  localparam logic [1:0] OP_CASCADE = 2'h3;
  localparam logic [1:0] XF_VERIFY = 2'h0;
  localparam logic [1:0] XF_WRITE = 2'h1;
  localparam logic [1:0] XF_READ = 2'h2;
  localparam logic [1:0] XF_ILLEGAL = 2'h3;

  // Reset values
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam logic CMD_EN_RST = 1'b0;
  localparam logic [4:0] MODE_RST = 5'h00;

  // Fixed channel roles
  localparam logic [2:0] BM_CHAN = 3'h4;
  localparam int BUF_ENTRIES = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_MASTER
  } ltc_state_t;

  // One issued transfer
  typedef struct packed {
    logic [16:0] addr;
    logic [2:0] chan;
    logic [1:0] kind;
    logic wide;
    logic last;
  } ltc_desc_t;
endpackage : ltc_pkg

/* tb/ltc_props.sv */
`timescale 1ns/1ps
module ltc_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic reg_rd,
  input wire logic [ltc_pkg::REG_DW-1:0] reg_rdata,
  // Requests and stream
  input wire logic [7:0] dreq,
  input wire logic bm_grant,
  input wire logic xfer_valid,
  input wire logic xfer_ready,
  input wire logic [16:0] xfer_addr,
  input wire logic [2:0] xfer_chan,
  input wire logic [1:0] xfer_kind,
  input wire logic xfer_wide,
  input wire logic xfer_last
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Stream checks; a stalled head must not move
  a_head_holds: assert property (xfer_valid && !xfer_ready |=> xfer_valid
    && $stable({xfer_addr, xfer_chan, xfer_kind, xfer_wide, xfer_last}))
    else $error("head changed under stall");
  a_no_master_xfer: assert property (xfer_valid |-> xfer_chan != 3'h4)
    else $error("transfer on channel 4");
  a_width_by_chan: assert property (xfer_valid |-> xfer_wide == xfer_chan[2])
    else $error("wrong transfer width");
  a_word_aligned: assert property (xfer_valid && xfer_wide |-> !xfer_addr[0])
    else $error("odd word address");
  a_kind_legal: assert property (xfer_valid |-> xfer_kind != 2'h3)
    else $error("illegal transfer kind");
  // Read data only in the cycle after a strobe
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  // Grant follows the channel 4 request both ways
  a_grant_cause: assert property ($rose(bm_grant) |-> $past(dreq[4]))
    else $error("grant without request");
  a_grant_drop: assert property (bm_grant && !dreq[4] |=> !bm_grant)
    else $error("grant held after request fell");
  c_stall: cover property (xfer_valid && !xfer_ready);
  c_grant: cover property (bm_grant);
  c_wide: cover property (xfer_valid && xfer_wide);
endmodule : ltc_props

bind ltc_top ltc_props i_ltc_props (.mclk(mclk), .reset(reset),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dreq(dreq), .bm_grant(bm_grant),
  .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_addr(xfer_addr),
  .xfer_chan(xfer_chan), .xfer_kind(xfer_kind), .xfer_wide(xfer_wide),
  .xfer_last(xfer_last));

/* tb/ltc_sink.sv */
`timescale 1ns/1ps
module ltc_sink (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Stall request from the bench
  input wire logic stall,
  // Transfer stream
  input wire logic xfer_valid,
  output logic xfer_ready = 1'b0,
  input wire ltc_pkg::ltc_desc_t desc
);
  // Accepted transfers, oldest first
  ltc_pkg::ltc_desc_t got [$];
  // Ready lags stall by one edge, like a slow consumer
  always @(posedge mclk) begin
    xfer_ready <= !stall && !reset;
    if (!reset && xfer_valid && xfer_ready) begin
      got.push_back(desc);
    end
  end
endmodule : ltc_sink

/* tb/test_ltc_top.sv */
`timescale 1ns/1ps
module test_ltc_top;
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] d;
    logic w;
    logic [15:0] e;
  } ltc_row_t;
  // Address, write data, write flag, expected read
  ltc_row_t rows [8] = '{'{8'h34, 16'h0000, 1'b0, 16'h000F},
    '{8'h28, 16'h0000, 1'b0, 16'h0000}, '{8'h2C, 16'h0000, 1'b0, 16'h00C0},
    '{8'h00, 16'h1234, 1'b1, 16'h1234}, '{8'h02, 16'h0000, 1'b0, 16'h1234},
    '{8'h11, 16'hABCD, 1'b1, 16'hABCD}, '{8'h1F, 16'h0FFF, 1'b1, 16'h0FFF},
    '{8'h3F, 16'h5555, 1'b1, 16'h0000}};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] dreq = 8'h00;
  logic stall = 1'b0;
  logic [15:0] reg_rdata;
  logic bm_grant, xfer_valid, xfer_ready, xfer_wide, xfer_last;
  logic [16:0] xfer_addr;
  logic [2:0] xfer_chan;
  logic [1:0] xfer_kind;
  int n_fail = 0;
  int checks = 0;
  always #5 mclk = ~mclk;
  ltc_top i_ltc_top (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dreq(dreq), .bm_grant(bm_grant),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_addr(xfer_addr),
    .xfer_chan(xfer_chan), .xfer_kind(xfer_kind), .xfer_wide(xfer_wide),
    .xfer_last(xfer_last));
  ltc_sink i_ltc_sink (.mclk(mclk), .reset(reset), .stall(stall),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
    .desc({xfer_addr, xfer_chan, xfer_kind, xfer_wide, xfer_last}));
  task automatic cmp16(string n, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : cmp16
  task automatic cmpd(ltc_pkg::ltc_desc_t e, ltc_pkg::ltc_desc_t s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value xfer exp %h got %h", e, s);
    end
  endtask : cmpd
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rdc(logic [7:0] a, logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 cmp16("reg", e, reg_rdata);
  endtask : rdc
  task automatic req(logic [7:0] v);
    @(posedge mclk);
    dreq <= v;
  endtask : req
  // Bounded wait for the next accepted transfer
  task automatic getx(ltc_pkg::ltc_desc_t e);
    int k;
    k = 0;
    while (i_ltc_sink.got.size() == 0 && k < 60) begin
      @(posedge mclk);
      k++;
    end
    if (i_ltc_sink.got.size() == 0) cmpd(e, 'x);
    else cmpd(e, i_ltc_sink.got.pop_front());
  endtask : getx
  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // Watchdog at 20000 cycles, far beyond the 130 or so cycles the tests need
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    // Channel 1 single read, count 1, consumer stalled until both queued
    wr(8'h04, 16'h0040);
    wr(8'h05, 16'h0001);
    // Decrement bit set on purpose: the address must still count up
    wr(8'h20, 16'h0069);
    rdc(8'h29, 16'h0049);
    wr(8'h34, 16'h0000);
    wr(8'h30, 16'h0004);
    stall <= 1'b1;
    req(8'h02);
    repeat (8) @(posedge mclk);
    req(8'h00);
    stall <= 1'b0;
    getx('{17'h00040, 3'h1, 2'h2, 1'b0, 1'b0});
    getx('{17'h00041, 3'h1, 2'h2, 1'b0, 1'b1});
    rdc(8'h34, 16'h0002);
    rdc(8'h32, 16'h0002);
    rdc(8'h32, 16'h0000);
    // Channel 5 demand write with auto-init, count 0
    wr(8'h14, 16'h0100);
    wr(8'h21, 16'h0015);
    wr(8'h35, 16'h0000);
    wr(8'h31, 16'h0004);
    req(8'h20);
    repeat (3) getx('{17'h00200, 3'h5, 2'h1, 1'b1, 1'b1});
    req(8'h00);
    repeat (10) @(posedge mclk);
    i_ltc_sink.got.delete();
    rdc(8'h35, 16'h0000);
    rdc(8'h16, 16'h0100);
    // Bus-master request on channel 4
    req(8'h10);
    repeat (3) @(posedge mclk);
    #1 cmp16("grant", 16'h0001, {15'h0000, bm_grant});
    req(8'h00);
    repeat (3) @(posedge mclk);
    #1 cmp16("grant", 16'h0000, {15'h0000, bm_grant});
    // Other command bits set, enable clear: nothing moves
    wr(8'h20, 16'h0040);
    wr(8'h34, 16'h0000);
    wr(8'h30, 16'h00FB);
    req(8'h05);
    repeat (10) @(posedge mclk);
    #1 cmp16("valid", 16'h0000, {15'h0000, xfer_valid});
    // Enable with rotating bit: still lowest channel first
    wr(8'h30, 16'h0014);
    getx('{17'h01234, 3'h0, 2'h0, 1'b0, 1'b1});
    getx('{17'h00000, 3'h2, 2'h0, 1'b0, 1'b1});
    req(8'h00);
    // Second reset after both channels have expired and been masked
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rdc(8'h34, 16'h000F);
    summarize();
  end
endmodule : test_ltc_top
